//--- rtl/sbcrf_core.sv
// Control core: reset pulse, aux enable, limp-home, supplies, CAN modes.
// Assumes pin comparators, one AHB-Lite master and one 40 MHz clock.
`timescale 1ns/1ps

// How it works
// R1: Supply or mode-exit resets pick length by resistor.
// R2: All other reset causes give short pulse.
// R3: Aux enable high when bit set, normal mode.
// R4: Aux bit writable only in normal or standby.
// R5: Any reset forces aux enable low.
// R6: Every system reset sets the warn bit.
// R7: Repeat reset with warn set sets force.
// R8: Limp-home output is open drain, low active.
// R9: Overtemp holds the force bit set.
// R10: Software clears force bit, limp-home releases.
// R11: Software clears warn bit after each reset.
// R12: Low battery enters off; recovery enters standby.
// R13: Leaving off sets the power-on flag.
// R14: Main undervoltage resets at selected 90/70 level.
// R15: Main supply at 90 percent raises warning.
// R16: Mode 10 switches the CAN regulator off.
// R17: CAN supply below 90 percent raises warning.
// R18: CAN supply status real only in normal.
// R19: CAN active in normal, enabled, supply good.
// R20: Standby control set gives lowpower with wake.
// R21: Standby or sleep without control powers down.
// R22: Wake needs rec-dom-rec-dom within timeout.
// R23: External low reset line filtered; internal resets drive.
// R24: Writing one clears an interrupt flag.
// R25: Pulse and wake times are cycle parameters.
module sbcrf_core
  import sbcrf_pkg::*;
#(
  parameter int RST_SHORT_CYC = (`SBCRF_RST_SHORT_US * `SBCRF_CLK_KHZ) / 1000,
  parameter int RST_LONG_CYC  = (`SBCRF_RST_LONG_US * `SBCRF_CLK_KHZ) / 1000,
  parameter int WAKE_TO_CYC   = (`SBCRF_WAKE_TO_US * `SBCRF_CLK_KHZ) / 1000
) (
  // Clock and reset.
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESETN_I,
  // AHB-Lite slave.
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // Analog monitor inputs.
  input  wire logic        BATTERY_PIN_OK_I,
  input  wire logic        OVERTEMP_I,
  input  wire logic        MAIN_UV90_I,
  input  wire logic        MAIN_UV70_I,
  input  wire logic        CAN_SUPPLY_UV_I,
  input  wire logic        CAN_BUS_DOM_I,
  input  wire logic        RESET_RES_SENSE_I,
  // Reset cause from the watchdog logic, same clock.
  input  wire logic        WDOG_RESET_I,
  // Bidirectional system reset line.
  input  wire logic        SYS_RESET_LINE_N_I,
  output logic             SYS_RESET_LINE_N_O,
  output logic             SYS_RESET_LINE_OE_N_O,
  // Fail-safe and power outputs.
  output logic             AUX_EN_O,
  output logic             FALLBACK_N_O,
  output logic             FALLBACK_OE_N_O,
  output logic             CAN_REG_EN_O,
  output logic      [1:0]  CAN_XCVR_MODE_O,
  output logic             CAN_WAKE_O
);

  localparam int FLTR_CYC   = (`SBCRF_EXT_FLTR_US * `SBCRF_CLK_KHZ + 999) / 1000;
  localparam int WK_REC_CYC = (`SBCRF_WAKE_REC_US * `SBCRF_CLK_KHZ + 999) / 1000;
  localparam int WK_DOM_CYC = (`SBCRF_WAKE_DOM_US * `SBCRF_CLK_KHZ + 999) / 1000;
  localparam logic [7:0] SYNC_RST = `SBCRF_SYNC_RST;
  localparam int CW = `SBCRF_CNT_W;

  logic [7:0]       raw_pins;
  logic [7:0]       sync1_q;
  logic [7:0]       sync2_q;
  sbcrf_pins_type   pins;
  logic             main_uv90_dly_q;
  logic             can_uv_dly_q;
  logic             otemp_dly_q;
  sbcrf_aphase_type aph_q;
  logic [31:0]      rdata_q;
  logic             wr_mode;
  logic             wr_sup;
  logic             wr_int;
  sbcrf_opmode_type opmode_q;
  logic             aux_q;
  logic             warn_q;
  logic             force_q;
  logic             level_sel_q;
  logic             can_stby_q;
  logic [3:0]       int_flags_q;
  logic             off_q;
  logic             otemp_q;
  logic             is_normal;
  logic             main_trip;
  logic             hold_req;
  logic             sel_req;
  logic             short_req;
  logic             ext_low;
  logic [7:0]       fltr_cnt_q;
  logic [CW-1:0]    rst_cnt_q;
  logic             rst_active;
  logic             rst_hold_q;
  logic             sys_rst_evt;
  sbcrf_xcvr_type   xcvr;
  sbcrf_wake_type   wk_state_q;
  logic [CW-1:0]    wk_to_q;
  logic [7:0]       wk_ph_q;
  logic             wk_evt;

  // Word address match, shared by write strobes and read mux.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return (a & 8'hfc) == ofs;
  endfunction

  // Two-stage synchronisers for the pins.
  assign raw_pins = {RESET_RES_SENSE_I, SYS_RESET_LINE_N_I, CAN_BUS_DOM_I, CAN_SUPPLY_UV_I,
                     MAIN_UV70_I, MAIN_UV90_I, OVERTEMP_I, BATTERY_PIN_OK_I};
  generate
    for (genvar g = 0; g < 8; g++) begin : g_sync
      always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
          sync1_q[g] <= SYNC_RST[g];
          sync2_q[g] <= SYNC_RST[g];
        end else begin
          sync1_q[g] <= raw_pins[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate
  assign pins = sbcrf_pins_type'(sync2_q);

  // Delayed copies for edge detection.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      main_uv90_dly_q <= 1'b0;
      can_uv_dly_q    <= 1'b0;
      otemp_dly_q     <= 1'b0;
    end else begin
      main_uv90_dly_q <= pins.main_uv90;
      can_uv_dly_q    <= pins.can_uv;
      otemp_dly_q     <= otemp_q;
    end
  end

  // Off and overtemp tracking.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      off_q   <= 1'b0;
      otemp_q <= 1'b0;
    end else begin
      off_q   <= !pins.batt_ok;  // see R12
      otemp_q <= pins.batt_ok && pins.overtemp && (otemp_q || opmode_q != SBCRF_OP_SLEEP);
    end
  end

  assign is_normal = opmode_q[1] && !off_q && !otemp_q;

  // AHB-Lite address phase capture; zero wait states, always OKAY.
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      aph_q <= '0;
    end else if (HREADY_I) begin
      aph_q.valid <= HSEL_I && HTRANS_I[1];
      aph_q.write <= HWRITE_I;
      aph_q.addr  <= {HADDR_I[7:2], 2'b00};
    end
  end

  assign wr_mode = aph_q.valid && aph_q.write && hit(aph_q.addr, `SBCRF_MODE_CTRL_OFS);
  assign wr_sup  = aph_q.valid && aph_q.write && hit(aph_q.addr, `SBCRF_SUP_CTRL_OFS);
  assign wr_int  = aph_q.valid && aph_q.write && hit(aph_q.addr, `SBCRF_INT_STATUS_OFS);

  // Read data is registered during the address phase; unmapped words read zero.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      rdata_q <= '0;
    end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
      rdata_q <= '0;
      if (hit(HADDR_I[7:0], `SBCRF_MODE_CTRL_OFS)) begin
        rdata_q[`SBCRF_OPMODE_LSB +: 2] <= opmode_q;
        rdata_q[`SBCRF_AUX_BIT]         <= aux_q;
        rdata_q[`SBCRF_WARN_BIT]        <= warn_q;
        rdata_q[`SBCRF_FORCE_BIT]       <= force_q;
      end else if (hit(HADDR_I[7:0], `SBCRF_SUP_CTRL_OFS)) begin
        rdata_q[`SBCRF_LEVEL_BIT]   <= level_sel_q;
        rdata_q[`SBCRF_CANSTBY_BIT] <= can_stby_q;
      end else if (hit(HADDR_I[7:0], `SBCRF_INT_STATUS_OFS)) begin
        rdata_q[3:0] <= int_flags_q;
      end else if (hit(HADDR_I[7:0], `SBCRF_DEV_STATUS_OFS)) begin
        rdata_q[`SBCRF_CANSTAT_BIT]    <= is_normal ? !pins.can_uv : 1'b1;  // see R18
        rdata_q[`SBCRF_XCVR_LSB +: 2]  <= xcvr;
        rdata_q[`SBCRF_RSTACT_BIT]     <= rst_active;
        rdata_q[`SBCRF_OTEMP_BIT]      <= otemp_q;
        rdata_q[`SBCRF_LIMP_BIT]       <= force_q;
      end
    end
  end
  assign HRDATA_O = rdata_q;

  // Reset causes: length-selectable ones, plain short ones, and level holds.
  assign main_trip = level_sel_q ? pins.main_uv70 : pins.main_uv90;  // see R14
  assign ext_low   = !pins.rst_line && SYS_RESET_LINE_OE_N_O;
  assign sel_req   = (main_trip && !off_q) || (off_q && pins.batt_ok)
                     || (otemp_dly_q && !otemp_q);  // see R1
  assign short_req = WDOG_RESET_I || (fltr_cnt_q == 8'(FLTR_CYC));  // see R2
  assign hold_req  = sel_req || short_req || otemp_q || (main_trip && !off_q);

  // External reset filter: line low and undriven for the filter time.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I || !ext_low) begin
      fltr_cnt_q <= '0;
    end else if (fltr_cnt_q != 8'(FLTR_CYC)) begin
      fltr_cnt_q <= fltr_cnt_q + 8'h01;  // see R23
    end
  end

  // Reset pulse counter; reloaded while a cause is held so the pulse stretches.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      rst_cnt_q <= '0;
    end else if (off_q && !pins.batt_ok) begin
      rst_cnt_q <= '0;
    end else if (sel_req && !pins.res_sense) begin
      rst_cnt_q <= `SBCRF_CNT_W'(RST_LONG_CYC);  // see R1
    end else if (sel_req || short_req || otemp_q) begin
      rst_cnt_q <= `SBCRF_CNT_W'(RST_SHORT_CYC);  // see R2
    end else if (rst_cnt_q != '0) begin
      rst_cnt_q <= rst_cnt_q - `SBCRF_CNT_W'(1);
    end
  end
  assign rst_active = rst_cnt_q != '0;

  // One system reset event per rise of the combined cause request; a cause that starts while another is held gives none.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      rst_hold_q <= 1'b0;
    end else begin
      rst_hold_q <= hold_req;
    end
  end
  assign sys_rst_evt = hold_req && !rst_hold_q;

  // Internal resets pull the line low; released otherwise.
  assign SYS_RESET_LINE_N_O    = 1'b0;
  assign SYS_RESET_LINE_OE_N_O = !(rst_active && !short_req) && !(rst_active && fltr_cnt_q == '0);  // see R23

  // Mode control register; hardware effects win over software writes.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I || off_q) begin
      opmode_q <= sbcrf_opmode_type'(`SBCRF_OPMODE_RST);
      aux_q    <= 1'b0;
    end else begin
      if (wr_mode && !otemp_q) begin
        opmode_q <= sbcrf_opmode_type'(HWDATA_I[`SBCRF_OPMODE_LSB +: 2]);
        if (opmode_q != SBCRF_OP_SLEEP) begin
          aux_q <= HWDATA_I[`SBCRF_AUX_BIT];  // see R4
        end
      end
      if (otemp_q) begin
        opmode_q <= SBCRF_OP_STBY;
      end
      if (rst_active || sys_rst_evt) begin
        aux_q <= 1'b0;  // see R5
      end
    end
  end

  // Limp-home warning and force bits.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I || (off_q && !pins.batt_ok)) begin
      warn_q  <= 1'b0;
      force_q <= 1'b0;
    end else begin
      if (wr_mode) begin
        warn_q  <= HWDATA_I[`SBCRF_WARN_BIT];   // see R11
        force_q <= HWDATA_I[`SBCRF_FORCE_BIT];  // see R10
      end
      if (sys_rst_evt) begin
        warn_q <= 1'b1;  // see R6
        if (warn_q) begin
          force_q <= 1'b1;  // see R7
        end
      end
      if (otemp_q) begin
        force_q <= 1'b1;  // see R9
      end
    end
  end

  // Supply control register.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I || off_q) begin
      level_sel_q <= 1'b0;
      can_stby_q  <= 1'b0;
    end else if (wr_sup) begin
      level_sel_q <= HWDATA_I[`SBCRF_LEVEL_BIT];
      can_stby_q  <= HWDATA_I[`SBCRF_CANSTBY_BIT];
    end
  end

  // Interrupt flags: write one to clear, a same-cycle event keeps its flag set.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      int_flags_q                 <= '0;
      int_flags_q[`SBCRF_PON_BIT] <= `SBCRF_PON_RST;
    end else if (off_q && !pins.batt_ok) begin
      int_flags_q <= '0;
    end else begin
      if (wr_int) begin
        int_flags_q <= int_flags_q & ~HWDATA_I[3:0];  // see R24
      end
      if (off_q) begin
        int_flags_q[`SBCRF_PON_BIT] <= 1'b1;  // see R13
      end
      if (pins.main_uv90 && !main_uv90_dly_q) begin
        int_flags_q[`SBCRF_MAINW_BIT] <= 1'b1;  // see R15
      end
      if (pins.can_uv && !can_uv_dly_q && CAN_REG_EN_O) begin
        int_flags_q[`SBCRF_CANW_BIT] <= 1'b1;  // see R17
      end
      if (wk_evt) begin
        int_flags_q[`SBCRF_WAKE_BIT] <= 1'b1;
      end
    end
  end

  // Transceiver power state.
  always_comb begin
    if (off_q || otemp_q) begin
      xcvr = SBCRF_XCVR_OFF;
    end else if (can_stby_q) begin
      xcvr = SBCRF_XCVR_LOWPWR;  // see R20
    end else if (is_normal && !pins.can_uv) begin
      xcvr = SBCRF_XCVR_ACTIVE;  // see R19
    end else begin
      xcvr = SBCRF_XCVR_OFF;  // see R21
    end
  end

  // Wake filter: each phase needs its minimum time, glitches restart only the phase timer.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I || xcvr != SBCRF_XCVR_LOWPWR) begin
      wk_state_q <= SBCRF_WK_REC1;
      wk_to_q    <= '0;
      wk_ph_q    <= '0;
    end else begin
      if (wk_state_q != SBCRF_WK_REC1) begin
        wk_to_q <= wk_to_q + `SBCRF_CNT_W'(1);
      end
      if (wk_to_q == `SBCRF_CNT_W'(WAKE_TO_CYC)) begin
        wk_state_q <= SBCRF_WK_REC1;  // see R22
        wk_to_q    <= '0;
        wk_ph_q    <= '0;
      end else if (pins.bus_dom != wk_state_q[0]) begin
        wk_ph_q <= '0;
      end else if (wk_ph_q + 8'h01 >= (wk_state_q[0] ? 8'(WK_DOM_CYC) : 8'(WK_REC_CYC))) begin
        wk_ph_q    <= '0;
        wk_state_q <= sbcrf_wake_type'(wk_state_q + 2'b01);  // see R22
        if (wk_state_q == SBCRF_WK_DOM2) begin
          wk_to_q <= '0;
        end
      end else begin
        wk_ph_q <= wk_ph_q + 8'h01;
      end
    end
  end
  assign wk_evt = xcvr == SBCRF_XCVR_LOWPWR && wk_state_q == SBCRF_WK_DOM2 && pins.bus_dom
                  && wk_to_q != `SBCRF_CNT_W'(WAKE_TO_CYC)
                  && wk_ph_q + 8'h01 >= 8'(WK_DOM_CYC);  // see R25

  // Registered outputs.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      AUX_EN_O        <= 1'b0;
      FALLBACK_OE_N_O <= 1'b1;
      CAN_REG_EN_O    <= 1'b0;
      CAN_XCVR_MODE_O <= SBCRF_XCVR_OFF;
      CAN_WAKE_O      <= 1'b0;
    end else begin
      AUX_EN_O        <= aux_q && opmode_q[1] && !rst_active && !sys_rst_evt && !off_q;  // see R3
      FALLBACK_OE_N_O <= !force_q;  // see R8
      CAN_REG_EN_O    <= !off_q && !otemp_q && opmode_q != SBCRF_OP_NORM0;  // see R16
      CAN_XCVR_MODE_O <= xcvr;
      CAN_WAKE_O      <= wk_evt;
    end
  end
  assign FALLBACK_N_O = 1'b0;

endmodule

//--- rtl/sbcrf_cfg.svh
// Offsets, fields, reset values and timings of the control core.
// Assumes a 40 MHz clock; included by bare name.
`ifndef SBCRF_CFG_SVH
`define SBCRF_CFG_SVH

// Clock rate in kHz.
`define SBCRF_CLK_KHZ          40000
// Register byte offsets.
`define SBCRF_MODE_CTRL_OFS    8'h00
`define SBCRF_SUP_CTRL_OFS     8'h04
`define SBCRF_INT_STATUS_OFS   8'h08
`define SBCRF_DEV_STATUS_OFS   8'h0c
// Mode control fields.
`define SBCRF_OPMODE_LSB       0
`define SBCRF_AUX_BIT          2
`define SBCRF_WARN_BIT         3
`define SBCRF_FORCE_BIT        4
// Supply control fields.
`define SBCRF_LEVEL_BIT        0
`define SBCRF_CANSTBY_BIT      1
// Interrupt status fields.
`define SBCRF_PON_BIT          0
`define SBCRF_MAINW_BIT        1
`define SBCRF_CANW_BIT         2
`define SBCRF_WAKE_BIT         3
// Device status fields.
`define SBCRF_CANSTAT_BIT      0
`define SBCRF_XCVR_LSB         1
`define SBCRF_RSTACT_BIT       3
`define SBCRF_OTEMP_BIT        4
`define SBCRF_LIMP_BIT         5
// Reset values.
`define SBCRF_OPMODE_RST       2'h0
`define SBCRF_PON_RST          1'h1
`define SBCRF_SYNC_RST         8'hc1
// Times in microseconds; counter width in bits.
`define SBCRF_RST_SHORT_US     1000
`define SBCRF_RST_LONG_US      20000
`define SBCRF_EXT_FLTR_US      1
`define SBCRF_WAKE_TO_US       1000
`define SBCRF_WAKE_REC_US      1
`define SBCRF_WAKE_DOM_US      1
`define SBCRF_CNT_W            20

`endif

//--- rtl/sbcrf_pkg.sv
// Types of the control core.
// Assumes sbcrf_cfg.svh is on the include path.
`include "sbcrf_cfg.svh"

package sbcrf_pkg;

  // Operating mode selection written by software.
  typedef enum logic [1:0] {
    SBCRF_OP_STBY  = 2'b00,
    SBCRF_OP_SLEEP = 2'b01,
    SBCRF_OP_NORM0 = 2'b10,
    SBCRF_OP_NORM1 = 2'b11
  } sbcrf_opmode_type;

  // CAN transceiver power state.
  typedef enum logic [1:0] {
    SBCRF_XCVR_OFF    = 2'b00,
    SBCRF_XCVR_LOWPWR = 2'b01,
    SBCRF_XCVR_ACTIVE = 2'b10
  } sbcrf_xcvr_type;

  // Phases of the remote wake filter.
  typedef enum logic [1:0] {
    SBCRF_WK_REC1 = 2'b00,
    SBCRF_WK_DOM1 = 2'b01,
    SBCRF_WK_REC2 = 2'b10,
    SBCRF_WK_DOM2 = 2'b11
  } sbcrf_wake_type;

  // Captured AHB address phase.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } sbcrf_aphase_type;

  // Synchronised pin levels.
  typedef struct packed {
    logic res_sense;
    logic rst_line;
    logic bus_dom;
    logic can_uv;
    logic main_uv70;
    logic main_uv90;
    logic overtemp;
    logic batt_ok;
  } sbcrf_pins_type;

endpackage

//--- verification/sbcrf_core_checker.sv
// Checker of the control core, watching its ports only.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps

module sbcrf_core_checker
  import sbcrf_pkg::*;
#(
  parameter int RST_SHORT_CYC = 50
) (
  // Clock and reset.
  input wire logic       SYS_CLK_I,
  input wire logic       RESETN_I,
  // Causes at the inputs.
  input wire logic       WDOG_RESET_I,
  input wire logic       OVERTEMP_I,
  input wire logic       CAN_SUPPLY_UV_I,
  input wire logic       CAN_BUS_DOM_I,
  // Driven pins.
  input wire logic       SYS_RESET_LINE_N_O,
  input wire logic       SYS_RESET_LINE_OE_N_O,
  input wire logic       AUX_EN_O,
  input wire logic       FALLBACK_N_O,
  input wire logic       FALLBACK_OE_N_O,
  input wire logic [1:0] CAN_XCVR_MODE_O,
  input wire logic       CAN_WAKE_O
);
  int low_cnt;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);

  // Cycles the device has pulled the reset line.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I || SYS_RESET_LINE_OE_N_O) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end

  // Causes held long enough to pass the input synchronisers.
  sequence s_hot;
    OVERTEMP_I [*6];
  endsequence
  sequence s_can_low;
    CAN_SUPPLY_UV_I [*6];
  endsequence

  chk_drive_low: assert property (!FALLBACK_N_O && !SYS_RESET_LINE_N_O)
    else $error("open-drain level not low");
  chk_wdog_pulse: assert property (WDOG_RESET_I |=> !SYS_RESET_LINE_OE_N_O)
    else $error("no reset pulse after watchdog cause");
  chk_pulse_min: assert property ($rose(SYS_RESET_LINE_OE_N_O) |-> low_cnt >= RST_SHORT_CYC - 1)
    else $error("reset pulse too short");
  chk_aux_drop: assert property (WDOG_RESET_I |-> ##4 !AUX_EN_O)
    else $error("aux enable high after reset");
  chk_hot_limp: assert property (s_hot |-> !FALLBACK_OE_N_O)
    else $error("limp-home released when hot");
  chk_hot_reset: assert property (s_hot |-> !SYS_RESET_LINE_OE_N_O)
    else $error("reset line released when hot");
  chk_xcvr_uv: assert property (s_can_low |-> CAN_XCVR_MODE_O != SBCRF_XCVR_ACTIVE)
    else $error("transceiver active on low supply");
  chk_wake_once: assert property (CAN_WAKE_O |=> !CAN_WAKE_O)
    else $error("wake pulse longer than a cycle");
  chk_wake_state: assert property (CAN_WAKE_O |-> CAN_XCVR_MODE_O == SBCRF_XCVR_LOWPWR && $past(CAN_BUS_DOM_I, 3))
    else $error("wake outside lowpower or dominant bus");
endmodule

bind sbcrf_core sbcrf_core_checker #(.RST_SHORT_CYC(RST_SHORT_CYC)) u_sbcrf_core_checker (
  .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .WDOG_RESET_I(WDOG_RESET_I), .OVERTEMP_I(OVERTEMP_I),
  .CAN_SUPPLY_UV_I(CAN_SUPPLY_UV_I), .CAN_BUS_DOM_I(CAN_BUS_DOM_I), .SYS_RESET_LINE_N_O(SYS_RESET_LINE_N_O),
  .SYS_RESET_LINE_OE_N_O(SYS_RESET_LINE_OE_N_O), .AUX_EN_O(AUX_EN_O), .FALLBACK_N_O(FALLBACK_N_O),
  .FALLBACK_OE_N_O(FALLBACK_OE_N_O), .CAN_XCVR_MODE_O(CAN_XCVR_MODE_O), .CAN_WAKE_O(CAN_WAKE_O));

//--- verification/sbcrf_host.sv
// Host model: single-word bus master issuing transfers by task.
// Assumes one slave whose ready output is fed back as the bus ready.
`timescale 1ns/1ps
`include "sbcrf_cfg.svh"

module sbcrf_host (
  // Bus clock.
  input  wire logic        clk_i,
  // Slave answer.
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  // Master request.
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  int n_stall = 0;

  // Bus idles until the first transfer.
  initial begin
    {hsel_o, haddr_o, htrans_o, hwrite_o, hsize_o, hwdata_o} = {1'b0, 32'h0, 2'b00, 1'b0, 3'h2, 32'h0};
  end

  // Waits, bounded, for ready sampled high at a rising edge.
  task automatic wait_ready();
    int k = 0;
    @(posedge clk_i);
    while (hready_i !== 1'b1 && k < 64) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 64) n_stall++;
  endtask

  // One transfer; called just after a rising edge, returns at the edge that ends it.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel_o <= 1'b1;
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    haddr_o <= {24'h0, a};
    wait_ready();
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    hwdata_o <= wd;
    wait_ready();
    rd = hrdata_i;
  endtask

  // Software recovery: clears warn and force bits.
  task automatic ack_reset(input logic [31:0] keep);
    logic [31:0] d;
    xfer(1'b1, `SBCRF_MODE_CTRL_OFS, keep & 32'h7, d);
  endtask
endmodule

//--- verification/tb_sbc_reset_failsafe_supply_ctl.sv
// Testbench of the control core.
// Assumes sbcrf_cfg.svh on the include path and the host model driving the bus.
`timescale 1ns/1ps
`include "sbcrf_cfg.svh"

module tb_sbc_reset_failsafe_supply_ctl
  import sbcrf_pkg::*;
;
  localparam int         short_cyc = 50;
  localparam int         long_cyc  = 200;
  localparam logic [7:0] a_mode    = `SBCRF_MODE_CTRL_OFS;
  localparam logic [7:0] a_sup     = `SBCRF_SUP_CTRL_OFS;
  localparam logic [7:0] a_int     = `SBCRF_INT_STATUS_OFS;
  localparam logic [7:0] a_dev     = `SBCRF_DEV_STATUS_OFS;
  logic sys_clk = 1'b0, resetn = 1'b0, batt_ok = 1'b1, otemp = 1'b0, uv90 = 1'b0, uv70 = 1'b0;
  logic can_uv = 1'b0, bus_dom = 1'b0, res_sense = 1'b0, wdog = 1'b0, ext_low = 1'b0, rd_phase = 1'b0;
  logic [63:0]      note;
  logic [63:0]      exp_q [$];
  logic [1:0]       order [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  int               seed = 13353, n_mismatch = 0, check_count = 0, n_wake = 0;
  wire logic        hsel, hwrite, hready, hresp, line_n, rl_o, rl_oe_n, aux_en, fb_n, fb_oe_n, can_reg, wake;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0]  htrans, xcvr;
  wire logic [2:0]  hsize;

  // Clock and the pulled-up reset line.
  always #12.5 sys_clk = ~sys_clk;
  assign line_n = (rl_oe_n ? 1'b1 : rl_o) & ~ext_low;

  sbcrf_core #(.RST_SHORT_CYC(short_cyc), .RST_LONG_CYC(long_cyc), .WAKE_TO_CYC(2000)) u_sbcrf_core (
    .SYS_CLK_I(sys_clk), .RESETN_I(resetn), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .BATTERY_PIN_OK_I(batt_ok), .OVERTEMP_I(otemp),
    .MAIN_UV90_I(uv90), .MAIN_UV70_I(uv70), .CAN_SUPPLY_UV_I(can_uv), .CAN_BUS_DOM_I(bus_dom),
    .RESET_RES_SENSE_I(res_sense), .WDOG_RESET_I(wdog), .SYS_RESET_LINE_N_I(line_n),
    .SYS_RESET_LINE_N_O(rl_o), .SYS_RESET_LINE_OE_N_O(rl_oe_n), .AUX_EN_O(aux_en), .FALLBACK_N_O(fb_n),
    .FALLBACK_OE_N_O(fb_oe_n), .CAN_REG_EN_O(can_reg), .CAN_XCVR_MODE_O(xcvr), .CAN_WAKE_O(wake));

  sbcrf_host u_sbcrf_host (.clk_i(sys_clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    n_mismatch += u_sbcrf_host.n_stall;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    u_sbcrf_host.xfer(1'b1, a, v, d);
  endtask

  // Notes the expected masked read value, then reads.
  task automatic rdx(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] d;
    exp_q.push_back({m, v});
    u_sbcrf_host.xfer(1'b0, a, 32'h0, d);
  endtask

  // Measures one reset pulse, each wait bounded.
  task automatic pulse(input int lo, input int hi);
    int k = 0;
    int n = 0;
    while (rl_oe_n !== 1'b0 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    while (rl_oe_n === 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    check("pulse width ok", 32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic phase(input logic dom, input int n);
    bus_dom <= dom;
    cyc(n);
  endtask

  task automatic rph(input logic dom);
    phase(dom, 45 + ($random(seed) & 63));
  endtask

  task automatic ack();
    u_sbcrf_host.ack_reset(32'h0);
  endtask

  // Compares each read data phase with the oldest noted expectation.
  always @(posedge sys_clk) begin
    if (rd_phase && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check("read data", hrdata & note[63:32], note[31:0]);
      check("okay resp", 32'(hresp), 32'h0);
    end
    rd_phase <= hsel && htrans[1] && !hwrite && hready;
  end

  // Counts wake pulses.
  always @(posedge sys_clk) begin
    if (wake === 1'b1) n_wake++;
  end

  // Cuts a hang short.
  initial begin
    cyc(60000);
    n_mismatch++;
    end_sim();
  end

  // Main sequence.
  initial begin
    cyc(4);
    resetn <= 1'b1;
    cyc(1);
    rdx(a_int, 32'h1, 32'h1);
    rdx(a_dev, 32'h7, 32'h1);
    rdx(8'h10, 32'hffffffff, 32'h0);
    ack();
    wr(a_int, 32'hf);
    rdx(a_int, 32'hf, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(a_mode, {27'($random(seed)), 3'h1, order[i]});
      cyc(4);
      check("aux enable", 32'(aux_en), 32'(order[i][1]));
      check("can regulator", 32'(can_reg), 32'(order[i] != 2'b10));
      check("xcvr mode", 32'(xcvr), order[i][1] ? 32'h2 : 32'h0);
    end
    cyc(260);
    u_sbcrf_host.ack_reset(32'h7);
    can_uv <= 1'b1;
    cyc(8);
    check("xcvr on low supply", 32'(xcvr), 32'h0);
    rdx(a_dev, 32'h1, 32'h0);
    rdx(a_int, 32'h4, 32'h4);
    can_uv <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wdog <= 1'b1;
      cyc(1);
      wdog <= 1'b0;
      pulse(short_cyc - 1, short_cyc + 4);
      check("aux reset", 32'(aux_en), 32'h0);
      check("limp-home", 32'(fb_oe_n), 32'(i == 0));
      rdx(a_mode, 32'h1c, i ? 32'h18 : 32'h08);
    end
    ack();
    cyc(3);
    check("limp cleared", 32'(fb_oe_n), 32'h1);
    wr(a_sup, 32'h1);
    uv90 <= 1'b1;
    cyc(8);
    check("no reset at 90", 32'(rl_oe_n), 32'h1);
    rdx(a_int, 32'h2, 32'h2);
    uv70 <= 1'b1;
    cyc(3);
    uv70 <= 1'b0;
    uv90 <= 1'b0;
    pulse(long_cyc - 8, long_cyc + 8);
    wr(a_sup, 32'h0);
    res_sense <= 1'b1;
    uv90 <= 1'b1;
    cyc(2);
    uv90 <= 1'b0;
    pulse(short_cyc - 1, short_cyc + 8);
    ack();
    ext_low <= 1'b1;
    cyc(30);
    check("ext no drive", 32'(rl_oe_n), 32'h1);
    cyc(30);
    ext_low <= 1'b0;
    cyc(60);
    rdx(a_mode, 32'h8, 32'h8);
    ack();
    res_sense <= 1'b0;
    otemp <= 1'b1;
    cyc(10);
    check("limp-home when hot", 32'(fb_oe_n), 32'h0);
    otemp <= 1'b0;
    pulse(long_cyc - 4, long_cyc + 12);
    ack();
    cyc(3);
    check("limp recovered", 32'(fb_oe_n), 32'h1);
    wr(a_int, 32'hf);
    batt_ok <= 1'b0;
    cyc(8);
    check("xcvr in off", 32'(xcvr), 32'h0);
    batt_ok <= 1'b1;
    pulse(long_cyc - 8, long_cyc + 16);
    rdx(a_int, 32'h1, 32'h1);
    ack();
    wr(a_sup, 32'h2);
    cyc(4);
    check("xcvr lowpower", 32'(xcvr), 32'h1);
    phase(1'b0, 60);
    for (int i = 0; i < 3; i++) phase(i[0], 10);
    phase(1'b0, 2100);
    check("short phases", 32'(n_wake), 32'h0);
    rph(1'b0);
    rph(1'b1);
    phase(1'b0, 5);
    rph(1'b1);
    rph(1'b0);
    rph(1'b1);
    phase(1'b0, 4);
    check("wake count", 32'(n_wake), 32'h1);
    rdx(a_int, 32'h8, 32'h8);
    cyc(4);
    end_sim();
  end
endmodule
